/* File: logic/tpc_pkg.sv */
`default_nettype none
package tpc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int DEB_TIME_US = 10_000;
  localparam int DEB_CYC = DEB_TIME_US * (CLK_HZ / 1_000_000);
  localparam int RPT_FIRST_MS = 500;
  localparam int RPT_FIRST_CYC = RPT_FIRST_MS * (CLK_HZ / 1000);
  localparam int RPT_NEXT_MS = 200;
  localparam int RPT_NEXT_CYC = RPT_NEXT_MS * (CLK_HZ / 1000);

  localparam logic [3:0] REG_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_STAT_OFS = 4'h4;
  localparam logic [3:0] REG_CODE_OFS = 4'h8;
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam logic CTRL_INHIBIT_RST = 1'h0;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_LAMP_LSB = 4;
  localparam int STAT_DISP_LSB = 16;
  localparam int STAT_FAULT_BIT = 24;
  localparam int CODE_FAULT_LSB = 0;
  localparam int CODE_SUB_LSB = 8;

  localparam logic [7:0] OP_FIRST = 8'h01;
  localparam logic [7:0] OP_LAST = 8'h03;
  localparam logic [7:0] SVC_FIRST = 8'h00;
  localparam logic [3:0] UNITS_MAX = 4'h9;
  localparam logic [7:0] DISP_BLANK = 8'h00;

  typedef enum logic [2:0] {
    MODE_STANDBY,
    MODE_READY,
    MODE_ONLINE,
    MODE_DIAG_OP,
    MODE_DIAG_SVC
  } tpc_mode_t;

  typedef struct packed {
    logic power_up;
    logic standby;
    logic mount;
    logic eject;
    logic attach;
    logic clear;
    logic test;
    logic step;
    logic execute;
    logic service;
  } tpc_keys_t;

  typedef struct packed {
    logic       mains_ok;
    logic       threaded;
    logic       loaded;
    logic       at_bot;
    logic       write_ring;
    logic       addr_equal;
    logic       decoder_ok;
    logic       busy;
    logic       fault_event;
    logic       test_done;
    logic [7:0] fault_code;
    logic [7:0] sub_code;
  } tpc_xport_t;

  typedef struct packed {
    logic load;
    logic rewind;
    logic unload;
    logic slow_unload;
    logic stop;
    logic abort;
    logic err_clear;
    logic test_start;
  } tpc_cmd_t;

  typedef struct packed {
    logic power_ready;
    logic tape_start;
    logic online;
    logic write_lock;
    logic addr_match;
    logic fault_diag;
    logic selftest_mode;
  } tpc_lamps_t;
endpackage
`default_nettype wire

/* File: logic/tpc_key_filter.sv */
`default_nettype none
module tpc_key_filter #(
  parameter int W       = 10,
  parameter int DEB_CYC = 100_000
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] raw_in,
  output logic [W-1:0]      level_out,
  output logic [W-1:0]      press_out
);
  localparam int CW = $clog2(DEB_CYC + 1);
  localparam logic [CW-1:0] CNT_END = CW'(DEB_CYC - 1);

  typedef struct packed {
    logic [W-1:0]          s1;
    logic [W-1:0]          s2;
    logic [W-1:0]          s3;
    logic [W-1:0]          level;
    logic [W-1:0]          press;
    logic [W-1:0][CW-1:0]  cnt;
  } tpc_filt_st_t;

  tpc_filt_st_t st_reg;
  tpc_filt_st_t st_next;

  // A key changes only after its synchronised level stays put for the whole count.
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = raw_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.press = '0;
    for (int i = 0; i < W; i++)
    begin
      if (st_reg.s2[i] == st_reg.s3[i] && st_reg.s3[i] != st_reg.level[i])
      begin
        if (st_reg.cnt[i] == CNT_END)
        begin
          st_next.level[i] = st_reg.s3[i];
          st_next.press[i] = st_reg.s3[i];
          st_next.cnt[i] = '0;
        end
        else
        begin
          st_next.cnt[i] = st_reg.cnt[i] + 1'b1;
        end
      end
      else
      begin
        st_next.cnt[i] = '0;
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign level_out = st_reg.level;
  assign press_out = st_reg.press;
endmodule
`default_nettype wire

/* File: logic/tpc_step_repeat.sv */
`default_nettype none
module tpc_step_repeat #(
  parameter int FIRST = 5_000_000,
  parameter int NEXT  = 2_000_000
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic held_in,
  input  wire logic press_in,
  output logic      tick_out
);
  localparam int CW = $clog2(FIRST + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } tpc_rpt_st_t;

  tpc_rpt_st_t st_reg;
  tpc_rpt_st_t st_next;

  // The press itself ticks once, then a long wait, then ticks at the shorter pace.
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (press_in)
    begin
      st_next.tick = 1'b1;
      st_next.cnt = CW'(FIRST - 1);
    end
    else if (held_in)
    begin
      if (st_reg.cnt == '0)
      begin
        st_next.tick = 1'b1;
        st_next.cnt = CW'(NEXT - 1);
      end
      else
      begin
        st_next.cnt = st_reg.cnt - 1'b1;
      end
    end
    else
    begin
      st_next.cnt = '0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick_out = st_reg.tick;
endmodule
`default_nettype wire

/* File: logic/tpc_panel_ctrl.sv */
// The address map and the Avalon-MM register port are this design's own decisions.
`default_nettype none
// Behaviour
// - Power-up key with mains present powers logic; ready lamp follows.
// - Tape start lamp follows the beginning-of-tape sensor.
// - Mount key loads threaded tape, or rewinds loaded tape.
// - Eject unloads at start, rewinds beyond it, slow-unloads threaded tape.
// - Attach key with tape loaded goes on-line and lights its lamp.
// - On-line, only clear and standby keys are obeyed.
// - Missing write ring lights lock lamp and blocks writes.
// - Address lamp needs address match, working decoder, no diagnostics.
// - Clear takes unit off-line, stops motion, clears latched errors.
// - Clear also aborts load or rewind and clears fault and test state.
// - Fault lamp lights in fault or diagnostics; display shows the code.
// - Self-test lamp stays lit from diagnostic entry until clear or standby.
// - Test key enters diagnostics only with tape threaded, not loaded.
// - Operator tests start at 01; step adds one up to 03.
// - Execute starts the test whose number is displayed.
// - Service key held with test enters service tests showing 00.
// - Service step adds one to units within 0 to 9; holding repeats.
// - Test after steps moves units to tens and clears units; old tens are lost.
// - Sub-fault code shows while service key is held, then fault returns.
module tpc_panel_ctrl #(
  parameter int DEB_CYC   = tpc_pkg::DEB_CYC,
  parameter int RPT_FIRST = tpc_pkg::RPT_FIRST_CYC,
  parameter int RPT_NEXT  = tpc_pkg::RPT_NEXT_CYC
) (
  input  wire logic               core_clk_in,
  input  wire logic               rst_n_in,
  input  wire tpc_pkg::tpc_keys_t  keys_in,
  input  wire tpc_pkg::tpc_xport_t xport_in,
  input  wire logic [3:0]         avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  input  wire logic [3:0]         avs_byteenable_in,
  output logic [31:0]             avs_readdata_out,
  output logic                    avs_waitrequest_out,
  output tpc_pkg::tpc_lamps_t     lamps_out,
  output tpc_pkg::tpc_cmd_t       cmd_out,
  output logic [7:0]              display_out,
  output logic [7:0]              test_num_out,
  output logic                    logic_power_out,
  output logic                    host_online_out,
  output logic                    write_permit_out
);
  typedef struct packed {
    tpc_pkg::tpc_mode_t  mode;
    logic                fault_lat;
    logic                term_lat;
    logic [7:0]          fault_code;
    logic [7:0]          sub_code;
    logic [7:0]          diag_num;
    logic                stepped;
    logic                inhibit;
    logic                wait_r;
    logic [31:0]         rdata;
    tpc_pkg::tpc_lamps_t lamps;
    tpc_pkg::tpc_cmd_t   cmd;
    logic [7:0]          disp;
    logic [7:0]          test_num;
    logic                power;
    logic                online;
    logic                wpermit;
  } tpc_main_st_t;

  tpc_main_st_t       st_reg;
  tpc_main_st_t       st_next;
  tpc_pkg::tpc_keys_t key_lvl;
  tpc_pkg::tpc_keys_t key_prs;
  logic               step_tick;
  logic               bus_req;
  logic               op_ok;
  logic               bare;

  function automatic logic is_diag(input tpc_pkg::tpc_mode_t m);
    is_diag = (m == tpc_pkg::MODE_DIAG_OP) || (m == tpc_pkg::MODE_DIAG_SVC);
  endfunction

  tpc_key_filter #(
    .W       ($bits(tpc_pkg::tpc_keys_t)),
    .DEB_CYC (DEB_CYC)
  ) u_filter (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .raw_in      (keys_in),
    .level_out   (key_lvl),
    .press_out   (key_prs)
  );

  tpc_step_repeat #(
    .FIRST (RPT_FIRST),
    .NEXT  (RPT_NEXT)
  ) u_repeat (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .held_in     (key_lvl.step),
    .press_in    (key_prs.step),
    .tick_out    (step_tick)
  );

  assign bus_req = avs_read_in | avs_write_in;
  assign op_ok = !st_reg.inhibit;
  assign bare = xport_in.threaded && !xport_in.loaded;

  always_comb
  begin
    st_next = st_reg;
    st_next.cmd = '0;
    case (st_reg.mode)
      tpc_pkg::MODE_STANDBY:
      begin
        if (key_prs.power_up && xport_in.mains_ok)
          st_next.mode = tpc_pkg::MODE_READY;
      end
      tpc_pkg::MODE_READY:
      begin
        if (key_prs.mount && op_ok)
        begin
          if (xport_in.loaded)
            st_next.cmd.rewind = 1'b1;
          else if (xport_in.threaded)
            st_next.cmd.load = 1'b1;
        end
        if (key_prs.eject && op_ok)
        begin
          if (xport_in.loaded && xport_in.at_bot)
            st_next.cmd.unload = 1'b1;
          else if (xport_in.loaded)
            st_next.cmd.rewind = 1'b1;
          else if (xport_in.threaded)
            st_next.cmd.slow_unload = 1'b1;
        end
        if (key_prs.attach && op_ok && xport_in.loaded)
          st_next.mode = tpc_pkg::MODE_ONLINE;
        if (key_prs.test && op_ok && bare)
        begin
          st_next.stepped = 1'b0;
          st_next.term_lat = 1'b0;
          if (key_lvl.service)
          begin
            st_next.mode = tpc_pkg::MODE_DIAG_SVC;
            st_next.diag_num = tpc_pkg::SVC_FIRST;
          end
          else
          begin
            st_next.mode = tpc_pkg::MODE_DIAG_OP;
            st_next.diag_num = tpc_pkg::OP_FIRST;
          end
        end
      end
      tpc_pkg::MODE_ONLINE:
      begin
        // Every other key is dropped here.
        st_next.mode = tpc_pkg::MODE_ONLINE;
      end
      tpc_pkg::MODE_DIAG_OP:
      begin
        if (key_prs.step && st_reg.diag_num != tpc_pkg::OP_LAST)
          st_next.diag_num = st_reg.diag_num + 8'h01;
      end
      tpc_pkg::MODE_DIAG_SVC:
      begin
        if (step_tick)
        begin
          st_next.stepped = 1'b1;
          if (st_reg.diag_num[3:0] == tpc_pkg::UNITS_MAX)
            st_next.diag_num[3:0] = 4'h0;
          else
            st_next.diag_num[3:0] = st_reg.diag_num[3:0] + 4'h1;
        end
        else if (key_prs.test && st_reg.stepped)
        begin
          st_next.diag_num = {st_reg.diag_num[3:0], 4'h0};
          st_next.stepped = 1'b0;
        end
      end
      default:
      begin
        st_next.mode = tpc_pkg::MODE_STANDBY;
      end
    endcase

    if (is_diag(st_reg.mode) && key_prs.execute)
    begin
      st_next.cmd.test_start = 1'b1;
      st_next.test_num = st_reg.diag_num;
      st_next.term_lat = 1'b0;
    end

    if (key_prs.clear && st_reg.mode != tpc_pkg::MODE_STANDBY)
    begin
      st_next.mode = tpc_pkg::MODE_READY;
      st_next.cmd.stop = 1'b1;
      st_next.cmd.err_clear = 1'b1;
      st_next.cmd.abort = xport_in.busy;
      st_next.fault_lat = 1'b0;
      st_next.term_lat = 1'b0;
      st_next.diag_num = tpc_pkg::DISP_BLANK;
      st_next.stepped = 1'b0;
    end
    if (key_prs.standby)
    begin
      st_next.mode = tpc_pkg::MODE_STANDBY;
      st_next.cmd.stop = 1'b1;
    end

    // A fault event arriving with a clear is kept, so it lands after it; a test end is dropped once the mode leaves diagnostics.
    if (xport_in.fault_event)
    begin
      st_next.fault_lat = 1'b1;
      st_next.fault_code = xport_in.fault_code;
      st_next.sub_code = xport_in.sub_code;
    end
    if (xport_in.test_done && is_diag(st_next.mode))
    begin
      st_next.term_lat = 1'b1;
      st_next.fault_code = xport_in.fault_code;
      st_next.sub_code = xport_in.sub_code;
    end

    st_next.power = st_next.mode != tpc_pkg::MODE_STANDBY;
    st_next.lamps.power_ready = st_next.power;
    st_next.lamps.tape_start = xport_in.at_bot;
    st_next.online = st_next.mode == tpc_pkg::MODE_ONLINE;
    st_next.lamps.online = st_next.online;
    st_next.lamps.write_lock = !xport_in.write_ring;
    st_next.wpermit = xport_in.write_ring;
    st_next.lamps.addr_match = xport_in.addr_equal && xport_in.decoder_ok
                               && !is_diag(st_next.mode);
    st_next.lamps.selftest_mode = is_diag(st_next.mode);
    st_next.lamps.fault_diag = st_next.fault_lat || st_next.term_lat
                               || is_diag(st_next.mode);
    if ((st_next.fault_lat || st_next.term_lat) && key_lvl.service
        && !(is_diag(st_next.mode) && !st_next.term_lat))
      st_next.disp = st_next.sub_code;
    else if (st_next.term_lat || (st_next.fault_lat && !is_diag(st_next.mode)))
      st_next.disp = st_next.fault_code;
    else if (is_diag(st_next.mode))
      st_next.disp = st_next.diag_num;
    else
      st_next.disp = tpc_pkg::DISP_BLANK;

    // One wait cycle, then the answer; read data is held with it.
    st_next.wait_r = !(bus_req && st_reg.wait_r);
    if (bus_req && st_reg.wait_r)
    begin
      st_next.rdata = '0;
      if (avs_read_in)
      begin
        case (avs_address_in)
          tpc_pkg::REG_CTRL_OFS:
            st_next.rdata[tpc_pkg::CTRL_INHIBIT_BIT] = st_reg.inhibit;
          tpc_pkg::REG_STAT_OFS:
          begin
            st_next.rdata[tpc_pkg::STAT_MODE_LSB +: 3] = st_reg.mode;
            st_next.rdata[tpc_pkg::STAT_LAMP_LSB +: 7] = st_reg.lamps;
            st_next.rdata[tpc_pkg::STAT_DISP_LSB +: 8] = st_reg.disp;
            st_next.rdata[tpc_pkg::STAT_FAULT_BIT] = st_reg.fault_lat;
          end
          tpc_pkg::REG_CODE_OFS:
          begin
            st_next.rdata[tpc_pkg::CODE_FAULT_LSB +: 8] = st_reg.fault_code;
            st_next.rdata[tpc_pkg::CODE_SUB_LSB +: 8] = st_reg.sub_code;
          end
          default:
            st_next.rdata = '0;
        endcase
      end
    end
    if (avs_write_in && !st_reg.wait_r && avs_byteenable_in[0]
        && avs_address_in == tpc_pkg::REG_CTRL_OFS)
      st_next.inhibit = avs_writedata_in[tpc_pkg::CTRL_INHIBIT_BIT];
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      st_reg <= '0;
      st_reg.wait_r <= 1'b1;
      st_reg.inhibit <= tpc_pkg::CTRL_INHIBIT_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata_out = st_reg.rdata;
  assign avs_waitrequest_out = st_reg.wait_r;
  assign lamps_out = st_reg.lamps;
  assign cmd_out = st_reg.cmd;
  assign display_out = st_reg.disp;
  assign test_num_out = st_reg.test_num;
  assign logic_power_out = st_reg.power;
  assign host_online_out = st_reg.online;
  assign write_permit_out = st_reg.wpermit;

  default clocking dcb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_power_up_ready: assert property (
    st_reg.mode == tpc_pkg::MODE_STANDBY && key_prs.power_up
    && xport_in.mains_ok && !key_prs.standby
    |=> st_reg.mode == tpc_pkg::MODE_READY && lamps_out.power_ready && logic_power_out)
    else $error("power-up key did not reach ready");
  a_tape_start_lamp: assert property (
    $past(rst_n_in) |-> lamps_out.tape_start == $past(xport_in.at_bot))
    else $error("tape start lamp does not follow sensor");
  a_mount_load: assert property (
    st_reg.mode == tpc_pkg::MODE_READY && key_prs.mount && op_ok && bare
    |=> cmd_out.load && !cmd_out.rewind ##1 !cmd_out.load)
    else $error("mount key did not issue a single load");
  a_eject_unload: assert property (
    st_reg.mode == tpc_pkg::MODE_READY && key_prs.eject && op_ok
    && xport_in.loaded && xport_in.at_bot |=> cmd_out.unload && !cmd_out.rewind)
    else $error("eject at start did not unload");
  a_attach_online: assert property (
    st_reg.mode == tpc_pkg::MODE_READY && key_prs.attach && op_ok
    && xport_in.loaded && !key_prs.clear && !key_prs.standby
    |=> lamps_out.online && host_online_out)
    else $error("attach key did not go on-line");
  a_online_keys_ignored: assert property (
    st_reg.mode == tpc_pkg::MODE_ONLINE && !key_prs.clear && !key_prs.standby
    |=> st_reg.mode == tpc_pkg::MODE_ONLINE && cmd_out == '0)
    else $error("key obeyed while on-line");
  a_write_lock_lamp: assert property (
    $past(rst_n_in) |-> lamps_out.write_lock == !$past(xport_in.write_ring)
    && write_permit_out != lamps_out.write_lock)
    else $error("write lock lamp wrong");
  a_clear_offline: assert property (
    key_prs.clear && st_reg.mode != tpc_pkg::MODE_STANDBY && !key_prs.standby
    && !xport_in.fault_event && !xport_in.test_done
    |=> !host_online_out && cmd_out.stop && cmd_out.err_clear && !lamps_out.fault_diag)
    else $error("clear key did not clear");
  a_selftest_holds: assert property (
    lamps_out.selftest_mode && !key_prs.clear && !key_prs.standby
    |=> lamps_out.selftest_mode)
    else $error("self-test lamp dropped without clear");
  a_op_entry: assert property (
    st_reg.mode == tpc_pkg::MODE_READY && key_prs.test && op_ok && bare
    && !key_lvl.service && !key_prs.clear && !key_prs.standby && !xport_in.fault_event
    |=> display_out == tpc_pkg::OP_FIRST && lamps_out.selftest_mode)
    else $error("operator tests did not show first number");
  a_svc_times_ten: assert property (
    st_reg.mode == tpc_pkg::MODE_DIAG_SVC && key_prs.test && st_reg.stepped
    && !step_tick && !key_prs.clear && !key_prs.standby
    |=> st_reg.diag_num == {$past(st_reg.diag_num[3:0]), 4'h0})
    else $error("test key did not shift units to tens");
endmodule
`default_nettype wire

/* File: tb/tpc_operator_model.sv */
`default_nettype none
module tpc_operator_model (
  input  wire logic              core_clk_in,
  output var tpc_pkg::tpc_keys_t keys_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial keys_out = '0;

  // Contacts make for one cycle and break for one cycle before they settle, as real switches do.
  task automatic press(input tpc_pkg::tpc_keys_t k, input int hold);
    keys_out <= keys_out | k;
    @(posedge core_clk_in);
    keys_out <= keys_out & ~k;
    @(posedge core_clk_in);
    keys_out <= keys_out | k;
    repeat (hold) @(posedge core_clk_in);
    keys_out <= keys_out & ~k;
    repeat (14) @(posedge core_clk_in);
  endtask

  // A key held down across other presses, such as service before test.
  task automatic hold_key(input tpc_pkg::tpc_keys_t k);
    keys_out <= keys_out | k;
    repeat (14) @(posedge core_clk_in);
  endtask

  task automatic free_key(input tpc_pkg::tpc_keys_t k);
    keys_out <= keys_out & ~k;
    repeat (14) @(posedge core_clk_in);
  endtask
endmodule
`default_nettype wire

/* File: tb/tpc_panel_ctrl_tb_top.sv */
`default_nettype none
module tpc_panel_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam tpc_pkg::tpc_keys_t K_PWR = '{power_up:1'b1, default:1'b0};
  localparam tpc_pkg::tpc_keys_t K_SBY = '{standby:1'b1, default:1'b0};
  localparam tpc_pkg::tpc_keys_t K_MNT = '{mount:1'b1, default:1'b0};
  localparam tpc_pkg::tpc_keys_t K_EJ  = '{eject:1'b1, default:1'b0};
  localparam tpc_pkg::tpc_keys_t K_ATT = '{attach:1'b1, default:1'b0};
  localparam tpc_pkg::tpc_keys_t K_CLR = '{clear:1'b1, default:1'b0};
  localparam tpc_pkg::tpc_keys_t K_TST = '{test:1'b1, default:1'b0};
  localparam tpc_pkg::tpc_keys_t K_STP = '{step:1'b1, default:1'b0};
  localparam tpc_pkg::tpc_keys_t K_EXE = '{execute:1'b1, default:1'b0};
  localparam tpc_pkg::tpc_keys_t K_SVC = '{service:1'b1, default:1'b0};
  logic                core_clk_in = 1'b0;
  logic                rst_n_in    = 1'b0;
  tpc_pkg::tpc_keys_t  keys;
  tpc_pkg::tpc_xport_t xp          = '0;
  logic [3:0]          addr        = 4'h0;
  logic                rd          = 1'b0;
  logic                wr          = 1'b0;
  logic [31:0]         wdata       = 32'h0;
  logic [3:0]          be          = 4'h0;
  logic [31:0]         rdata;
  logic [31:0]         q;
  logic                waitreq;
  tpc_pkg::tpc_lamps_t lamps;
  tpc_pkg::tpc_cmd_t   cmd;
  logic [7:0]          disp;
  logic [7:0]          tnum;
  logic                pwr;
  logic                onl;
  logic                wperm;
  logic [7:0]          seen        = 8'h00;
  int                  mismatches  = 0;
  int                  comparisons = 0;

  always #50 core_clk_in = ~core_clk_in;

  // Command pulses last one cycle, so they are gathered between presses.
  always @(posedge core_clk_in) seen = seen | cmd;

  tpc_panel_ctrl #(.DEB_CYC(4), .RPT_FIRST(20), .RPT_NEXT(8)) tpc_panel_ctrl_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .keys_in(keys), .xport_in(xp),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .lamps_out(lamps), .cmd_out(cmd),
    .display_out(disp), .test_num_out(tnum), .logic_power_out(pwr),
    .host_online_out(onl), .write_permit_out(wperm)
  );

  tpc_operator_model tpc_operator_model_i (.core_clk_in(core_clk_in), .keys_out(keys));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] r);
    addr <= a;
    wdata <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    @(posedge core_clk_in);
    while (waitreq !== 1'b0)
    begin
      @(posedge core_clk_in);
    end
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, 4'hF, r);
    chk(r, e);
  endtask

  task automatic act(input tpc_pkg::tpc_keys_t k, input logic [7:0] e);
    seen = 8'h00;
    tpc_operator_model_i.press(k, 14);
    chk(seen, e);
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    chk(lamps, 7'h00);
    chk(waitreq, 1'b1);
    rchk(4'h0, 32'h0);
    rchk(4'hC, 32'h0);
    xp <= '{mains_ok:1'b1, threaded:1'b1, at_bot:1'b1, addr_equal:1'b1,
            decoder_ok:1'b1, default:'0};
    act(K_MNT, 8'h00);
    tpc_operator_model_i.press(K_PWR, 14);
    chk(lamps, 7'h6C);
    chk(pwr, 1'b1);
    chk(wperm, 1'b0);
    xp.write_ring <= 1'b1;
    xp.at_bot <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    chk(lamps, 7'h44);
    chk(wperm, 1'b1);
    act(K_MNT, 8'h80);
    // Mount is refused while the inhibit bit is set; a write without byte 0 is lost.
    bus(1'b1, 4'h0, 32'h1, 4'h0, q);
    rchk(4'h0, 32'h0);
    bus(1'b1, 4'h0, 32'h1, 4'hF, q);
    rchk(4'h0, 32'h1);
    act(K_MNT, 8'h00);
    bus(1'b1, 4'h0, 32'h0, 4'hF, q);
    xp.loaded <= 1'b1;
    act(K_MNT, 8'h40);
    xp.at_bot <= 1'b1;
    act(K_EJ, 8'h20);
    xp.at_bot <= 1'b0;
    act(K_EJ, 8'h40);
    xp.loaded <= 1'b0;
    act(K_EJ, 8'h10);
    xp.loaded <= 1'b1;
    act(K_ATT, 8'h00);
    chk(lamps.online, 1'b1);
    chk(onl, 1'b1);
    act(K_MNT, 8'h00);
    act(K_EJ, 8'h00);
    xp.busy <= 1'b1;
    act(K_CLR, 8'h0E);
    chk(onl, 1'b0);
    xp.busy <= 1'b0;
    xp.fault_code <= 8'h42;
    xp.sub_code <= 8'h17;
    xp.fault_event <= 1'b1;
    @(posedge core_clk_in);
    xp.fault_event <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    chk(lamps.fault_diag, 1'b1);
    chk(disp, 8'h42);
    rchk(4'h4, 32'h01420461);
    rchk(4'h8, 32'h00001742);
    tpc_operator_model_i.hold_key(K_SVC);
    chk(disp, 8'h17);
    tpc_operator_model_i.free_key(K_SVC);
    chk(disp, 8'h42);
    act(K_CLR, 8'h0A);
    chk(lamps.fault_diag, 1'b0);
    chk(disp, 8'h00);
    act(K_TST, 8'h00);
    chk(lamps.selftest_mode, 1'b0);
    xp.loaded <= 1'b0;
    act(K_TST, 8'h00);
    chk(disp, 8'h01);
    chk(lamps.selftest_mode, 1'b1);
    chk(lamps.addr_match, 1'b0);
    for (int i = 2; i < 5; i++)
    begin
      act(K_STP, 8'h00);
      chk(disp, (i > 3) ? 8'h03 : 8'(i));
    end
    act(K_EXE, 8'h01);
    chk(tnum, 8'h03);
    // A finished test shows its termination code in place of the test number.
    xp.fault_code <= 8'h21;
    xp.test_done <= 1'b1;
    @(posedge core_clk_in);
    xp.test_done <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    chk(disp, 8'h21);
    chk(lamps.fault_diag, 1'b1);
    chk(lamps.selftest_mode, 1'b1);
    act(K_CLR, 8'h0A);
    chk(lamps.selftest_mode, 1'b0);
    tpc_operator_model_i.hold_key(K_SVC);
    act(K_TST, 8'h00);
    tpc_operator_model_i.free_key(K_SVC);
    chk(disp, 8'h00);
    chk(lamps.selftest_mode, 1'b1);
    for (int i = 0; i < 3; i++)
      act(K_STP, 8'h00);
    chk(disp, 8'h03);
    act(K_TST, 8'h00);
    chk(disp, 8'h30);
    tpc_operator_model_i.press(K_STP, 32);
    chk(disp, 8'h33);
    for (int i = 0; i < 6; i++)
      act(K_STP, 8'h00);
    chk(disp, 8'h39);
    act(K_STP, 8'h00);
    chk(disp, 8'h30);
    act(K_EXE, 8'h01);
    chk(tnum, 8'h30);
    act(K_CLR, 8'h0A);
    act(K_SBY, 8'h08);
    chk(lamps.power_ready, 1'b0);
    chk(pwr, 1'b0);
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
